// file: verilog/dlic_top.v
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "dlic_map.vh"

module dlic_top (
  input wire clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`DLIC_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [31:0] source_lines,
  output reg normal_interrupt_request,
  output reg fast_interrupt_request,
  output wire event_irq
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  reg [31:0] src_q;
  reg [31:0] normal_enable_mask;
  reg [31:0] fast_enable_mask;
  reg [31:0] soft_interrupt_config;
  reg [`DLIC_EVT_W-1:0] evt_status;
  reg [`DLIC_EVT_W-1:0] evt_mask;

  wire [31:0] byte_mask;
  wire [31:0] wdata;
  wire bus_req;
  wire wr_now;
  wire rd_now;
  wire fast_or;
  wire soft_normal;
  wire soft_fast;
  reg [31:0] normal_raw_source_flags;
  reg [31:0] normal_active_status;
  reg [31:0] fast_raw_source_flags;
  reg [31:0] fast_active_status;
  reg [31:0] next_rdata;
  reg wr_ignored;
  reg [`DLIC_EVT_W-1:0] evt_set;
  reg [`DLIC_EVT_W-1:0] evt_clr;

  // ----------------------------------------
  // byte lane expansion
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      assign byte_mask[gi*8+7:gi*8] = {8{wb_sel_i[gi]}};
    end
  endgenerate

  assign wdata = wb_dat_i & byte_mask;
  assign bus_req = wb_cyc_i & wb_stb_i;
  // write lands on the edge where ack is seen high
  assign wr_now = bus_req & wb_we_i & wb_ack_o;
  assign rd_now = bus_req & ~wb_ack_o;

  assign soft_normal = soft_interrupt_config[`DLIC_SOFT_NORMAL_BIT];
  assign soft_fast = soft_interrupt_config[`DLIC_SOFT_FAST_BIT];

  // ----------------------------------------
  // source flags and status
  // ----------------------------------------
  // sources held long
  // inputs are one register deep, not latched, so a pulse of one cycle shows in raw flags and status for one cycle only
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_q <= `DLIC_RST_WORD;
    end else begin
      src_q <= source_lines;
    end
  end

  assign fast_or = |fast_active_status[31:1];

  always @* begin
    normal_raw_source_flags = src_q;
    fast_raw_source_flags = src_q;
    normal_raw_source_flags[`DLIC_SRC_BIT] = fast_or;
    fast_raw_source_flags[`DLIC_SRC_BIT] = fast_or;
    normal_raw_source_flags[`DLIC_SOFT_BIT] =
      src_q[`DLIC_SOFT_BIT] | soft_normal;
    fast_raw_source_flags[`DLIC_SOFT_BIT] =
      src_q[`DLIC_SOFT_BIT] | soft_fast;
    normal_active_status = src_q & normal_enable_mask;
    fast_active_status = src_q & fast_enable_mask;
    normal_active_status[`DLIC_SOFT_BIT] =
      (src_q[`DLIC_SOFT_BIT] & normal_enable_mask[`DLIC_SOFT_BIT]) |
      soft_normal;
    fast_active_status[`DLIC_SOFT_BIT] =
      (src_q[`DLIC_SOFT_BIT] & fast_enable_mask[`DLIC_SOFT_BIT]) |
      soft_fast;
    // bit 0 excluded from the or-tree, so no loop here
    normal_active_status[`DLIC_SRC_BIT] =
      fast_or & normal_enable_mask[`DLIC_SRC_BIT];
    fast_active_status[`DLIC_SRC_BIT] = fast_or;
  end

  // ----------------------------------------
  // request outputs
  // ----------------------------------------
  // no encoder
  // software scans status itself; only plain levels leave here
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      normal_interrupt_request <= 1'b0;
      fast_interrupt_request <= 1'b0;
    end else begin
      normal_interrupt_request <= |normal_active_status;
      fast_interrupt_request <= fast_or;
    end
  end

  // ----------------------------------------
  // enable masks and soft config
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      normal_enable_mask <= `DLIC_RST_WORD;
      fast_enable_mask <= `DLIC_RST_WORD;
      soft_interrupt_config <= `DLIC_RST_WORD;
    end else if (wr_now) begin
      case (wb_adr_i)
        `DLIC_OFS_NORMAL_EN: begin
          normal_enable_mask <= normal_enable_mask | wdata;
          fast_enable_mask <= fast_enable_mask & ~wdata;
        end
        `DLIC_OFS_NORMAL_CLR: begin
          normal_enable_mask <= normal_enable_mask & ~wdata;
        end
        `DLIC_OFS_FAST_EN: begin
          fast_enable_mask <= fast_enable_mask | wdata;
          normal_enable_mask <= normal_enable_mask & ~wdata;
        end
        `DLIC_OFS_FAST_CLR: begin
          fast_enable_mask <= fast_enable_mask & ~wdata;
        end
        `DLIC_OFS_SOFT_CFG: begin
          soft_interrupt_config[`DLIC_SOFT_NORMAL_BIT] <= wb_sel_i[0] ?
            wb_dat_i[`DLIC_SOFT_NORMAL_BIT] : soft_normal;
          soft_interrupt_config[`DLIC_SOFT_FAST_BIT] <= wb_sel_i[0] ?
            wb_dat_i[`DLIC_SOFT_FAST_BIT] : soft_fast;
        end
        default: begin
          normal_enable_mask <= normal_enable_mask;
        end
      endcase
    end
  end

  // ----------------------------------------
  // event flags
  // ----------------------------------------
  always @* begin
    case (wb_adr_i)
      `DLIC_OFS_NORMAL_EN, `DLIC_OFS_NORMAL_CLR, `DLIC_OFS_FAST_EN,
      `DLIC_OFS_FAST_CLR, `DLIC_OFS_SOFT_CFG, `DLIC_OFS_EVT_STA,
      `DLIC_OFS_EVT_MASK: wr_ignored = 1'b0;
      default: wr_ignored = 1'b1;
    endcase
    evt_set = `DLIC_RST_EVT;
    evt_set[`DLIC_EVT_NORMAL_BIT] =
      (|normal_active_status) & ~normal_interrupt_request;
    evt_set[`DLIC_EVT_FAST_BIT] = fast_or & ~fast_interrupt_request;
    evt_set[`DLIC_EVT_IGNORED_BIT] = wr_now & wr_ignored;
    evt_clr = `DLIC_RST_EVT;
    if (wr_now && wb_adr_i == `DLIC_OFS_EVT_STA) begin
      evt_clr = wdata[`DLIC_EVT_W-1:0];
    end
  end

  // set wins over a clear in the same cycle
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_status <= `DLIC_RST_EVT;
      evt_mask <= `DLIC_RST_EVT;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      if (wr_now && wb_adr_i == `DLIC_OFS_EVT_MASK) begin
        evt_mask <= (evt_mask & ~byte_mask[`DLIC_EVT_W-1:0]) |
          wdata[`DLIC_EVT_W-1:0];
      end
    end
  end

  assign event_irq = |(evt_status & evt_mask);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  always @* begin
    case (wb_adr_i)
      `DLIC_OFS_NORMAL_RAW: next_rdata = normal_raw_source_flags;
      `DLIC_OFS_NORMAL_EN: next_rdata = normal_enable_mask;
      `DLIC_OFS_NORMAL_STA: next_rdata = normal_active_status;
      `DLIC_OFS_FAST_RAW: next_rdata = fast_raw_source_flags;
      `DLIC_OFS_FAST_EN: next_rdata = fast_enable_mask;
      `DLIC_OFS_FAST_STA: next_rdata = fast_active_status;
      `DLIC_OFS_SOFT_CFG: next_rdata = soft_interrupt_config;
      `DLIC_OFS_EVT_STA: next_rdata = {29'h0000_0000, evt_status};
      `DLIC_OFS_EVT_MASK: next_rdata = {29'h0000_0000, evt_mask};
      default: next_rdata = `DLIC_ZERO_WORD;
    endcase
  end

  // one wait state: ack the cycle after the request, drop after
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `DLIC_ZERO_WORD;
    end else begin
      wb_ack_o <= rd_now;
      if (rd_now) begin
        wb_dat_o <= wb_we_i ? `DLIC_ZERO_WORD : next_rdata;
      end
    end
  end

endmodule // dlic_top

// file: verilog/dlic_map.vh
`ifndef DLIC_MAP_VH
`define DLIC_MAP_VH

// ----------------------------------------
// register word offsets (byte addresses)
// ----------------------------------------
`define DLIC_ADR_W 8
`define DLIC_OFS_NORMAL_RAW 8'h00
`define DLIC_OFS_NORMAL_EN 8'h04
`define DLIC_OFS_NORMAL_CLR 8'h08
`define DLIC_OFS_NORMAL_STA 8'h0C
`define DLIC_OFS_FAST_RAW 8'h10
`define DLIC_OFS_FAST_EN 8'h14
`define DLIC_OFS_FAST_CLR 8'h18
`define DLIC_OFS_FAST_STA 8'h1C
`define DLIC_OFS_SOFT_CFG 8'h20
`define DLIC_OFS_EVT_STA 8'h24
`define DLIC_OFS_EVT_MASK 8'h28

// ----------------------------------------
// field positions
// ----------------------------------------
`define DLIC_SRC_BIT 0
`define DLIC_SOFT_BIT 1
`define DLIC_SOFT_NORMAL_BIT 1
`define DLIC_SOFT_FAST_BIT 2
`define DLIC_EVT_NORMAL_BIT 0
`define DLIC_EVT_FAST_BIT 1
`define DLIC_EVT_IGNORED_BIT 2
`define DLIC_EVT_W 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define DLIC_RST_WORD 32'h0000_0000
`define DLIC_RST_EVT 3'h0
`define DLIC_ZERO_WORD 32'h0000_0000

`endif

// file: sim/dlic_src_model.sv
`timescale 1ns/1ps
module dlic_src_model (
  input wire clk,
  input wire sys_rst,
  input wire [31:0] req,
  output reg [31:0] source_lines
);
  // lines held
  // level stays until the bench drops it, never a short pulse
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) source_lines <= 32'h0000_0000;
    else source_lines <= req;
  end
endmodule // dlic_src_model

// file: sim/dlic_chk.sv
`timescale 1ns/1ps
module dlic_chk (
  input wire clk,
  input wire sys_rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [31:0] source_lines
);
  reg [31:0] s1, s2;
  wire rd = wb_ack_o && !wb_we_i;
  // mirror only judged on a steady source, edges are ambiguous
  wire stab = (s1 == s2) && (s1 == source_lines);
  always @(posedge clk) begin
    s1 <= source_lines;
    s2 <= s1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence acc_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_wait_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> acc_s)
    else $error("ack not one cycle after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  clr_zero_a: assert property (
    rd && (wb_adr_i == 8'h08 || wb_adr_i == 8'h18) |-> wb_dat_o == 0)
    else $error("clear register read not zero");
  unmap_zero_a: assert property (
    rd && wb_adr_i > 8'h28 |-> wb_dat_o == 0)
    else $error("unmapped read not zero");
  soft_rsvd_a: assert property (
    rd && wb_adr_i == 8'h20 |-> wb_dat_o[31:3] == 0 && !wb_dat_o[0])
    else $error("soft config reserved bits set");
  nraw_mirror_a: assert property (
    rd && wb_adr_i == 8'h00 && stab |-> wb_dat_o[31:2] == s1[31:2])
    else $error("normal raw does not follow lines");
  fraw_mirror_a: assert property (
    rd && wb_adr_i == 8'h10 && stab |-> wb_dat_o[31:2] == s1[31:2])
    else $error("fast raw does not follow lines");
endmodule // dlic_chk
bind dlic_top dlic_chk i_dlic_chk (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .source_lines);

// file: sim/tb.sv
`timescale 1ns/1ps
module tb;
  reg clk, sys_rst, cyc, stb, we;
  reg [7:0] adr;
  reg [31:0] dat, req;
  wire [31:0] rdat, src;
  wire ack, nreq, freq, eirq;
  integer fail_count, checked;
  dlic_src_model i_dlic_src_model (.clk(clk), .sys_rst(sys_rst),
    .req(req), .source_lines(src));
  dlic_top i_dlic_top (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .source_lines(src), .normal_interrupt_request(nreq),
    .fast_interrupt_request(freq), .event_irq(eirq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task ck(input [31:0] g, input [31:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("FAIL %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wb(input [7:0] a, input w, input [31:0] d, input [31:0] e);
    integer n;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      n = 0;
      // look between edges, so ack and data are settled when seen
      @(negedge clk);
      while (ack !== 1'b1 && n < 20) begin
        n = n + 1;
        @(negedge clk);
      end
      if (!w) ck(rdat, e);
      if (n == 20) ck(n, 0);
      // the edge at which ack is sampled high ends the request
      @(posedge clk);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    wb(a, 1'b1, d, 0);
  endtask
  task rd(input [7:0] a, input [31:0] e);
    wb(a, 1'b0, 0, e);
  endtask
  // lines and requests need a few edges to settle
  task st;
    repeat (4) @(posedge clk);
  endtask
  task t_mask;
    begin
      req <= 32'h0000_0060;
      st;
      rd(8'h00, 32'h0000_0060);
      wr(8'h04, 32'h0000_0020);
      rd(8'h0c, 32'h0000_0020);
      st;
      ck(nreq, 1);
      wr(8'h04, 32'h0000_0000);
      rd(8'h04, 32'h0000_0020);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h00, 32'h0000_0060);
      rd(8'h08, 32'h0000_0000);
      wr(8'h08, 32'h0000_0020);
      rd(8'h04, 32'h0000_0000);
      st;
      ck(nreq, 0);
    end
  endtask
  task t_excl;
    begin
      wr(8'h04, 32'h0000_0040);
      wr(8'h14, 32'h0000_0040);
      rd(8'h04, 32'h0000_0000);
      rd(8'h1c, 32'h0000_0041);
      rd(8'h00, 32'h0000_0061);
      rd(8'h0c, 32'h0000_0000);
      ck(freq, 1);
      wr(8'h04, 32'h0000_0041);
      rd(8'h14, 32'h0000_0000);
      rd(8'h0c, 32'h0000_0040);
      wr(8'h08, 32'hffff_ffff);
    end
  endtask
  task t_soft;
    begin
      req <= 32'h0000_0000;
      wr(8'h20, 32'h0000_0004);
      rd(8'h10, 32'h0000_0003);
      st;
      ck(freq, 1);
      wr(8'h20, 32'h0000_0002);
      rd(8'h1c, 32'h0000_0000);
      rd(8'h0c, 32'h0000_0002);
      rd(8'h20, 32'h0000_0002);
      st;
      ck(nreq, 1);
      wr(8'h20, 32'hffff_fff9);
      rd(8'h20, 32'h0000_0000);
    end
  endtask
  task t_evt;
    begin
      wr(8'h28, 32'h0000_0000);
      wr(8'h24, 32'h0000_0007);
      wr(8'h40, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
      ck(eirq, 0);
      rd(8'h24, 32'h0000_0004);
      wr(8'h28, 32'h0000_0004);
      ck(eirq, 1);
      wr(8'h24, 32'h0000_0004);
      ck(eirq, 0);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    sys_rst = 1'b1;
    {cyc, stb, we, adr, dat, req} = 0;
    fail_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    t_mask;
    t_excl;
    t_soft;
    t_evt;
    end_of_test;
  end
  // whole run is under two hundred cycles
  initial begin
    #20000;
    fail_count = fail_count + 1;
    end_of_test;
  end
endmodule // tb
